// *** socf_pkg.sv ***
/*
 package for the sensor output configuration bank: register byte addresses,
 field positions, reset values and typical gain/range lookup data.
 assumes a 32-bit apb slave with one aligned word per register.
*/
package socf_pkg;
   // printed offsets are not all multiples of four: they are word indices
   localparam logic [7:0] SOCF_IDX_GAIN = 8'h08;
   localparam logic [7:0] SOCF_IDX_MODE = 8'h1c;
   localparam logic [7:0] SOCF_IDX_TRIM = 8'h1d;
   localparam logic [7:0] SOCF_IDX_SCRL = 8'h1f;
   localparam logic [7:0] SOCF_IDX_MULT = 8'h0a;
   localparam logic [7:0] SOCF_IDX_SENT = 8'h1e;
   localparam logic [7:0] SOCF_IDX_STAT = 8'h20;
   localparam logic [9:0] SOCF_ADDR_GAIN = {SOCF_IDX_GAIN, 2'b00};
   localparam logic [9:0] SOCF_ADDR_MODE = {SOCF_IDX_MODE, 2'b00};
   localparam logic [9:0] SOCF_ADDR_TRIM = {SOCF_IDX_TRIM, 2'b00};
   localparam logic [9:0] SOCF_ADDR_SCRL = {SOCF_IDX_SCRL, 2'b00};
   localparam logic [9:0] SOCF_ADDR_MULT = {SOCF_IDX_MULT, 2'b00};
   localparam logic [9:0] SOCF_ADDR_SENT = {SOCF_IDX_SENT, 2'b00};
   localparam logic [9:0] SOCF_ADDR_STAT = {SOCF_IDX_STAT, 2'b00};
   localparam int SOCF_GAIN_LSB = 2;
   localparam int SOCF_PROTO_BIT = 3;
   localparam int SOCF_OVT_BIT = 10;
   localparam int SOCF_SCRS_LSB = 12;
   localparam int SOCF_NIB_LSB = 3;
   localparam logic [3:0] SOCF_GAIN_RST = 4'h0;
   localparam logic [11:0] SOCF_MULT_RST = 12'h800;
   localparam logic [1:0] SOCF_NIB_RST = 2'h0;
   localparam logic SOCF_PROTO_SENT = 1'b0;
   localparam logic SOCF_PROTO_PWM = 1'b1;
   // typical gain, thousandths of %fso per gauss, indexed by coarse code
   localparam logic [15:0] SOCF_GAIN_TAB [16] = '{
      16'h0064, 16'h014d, 16'h00fa, 16'h00c8, 16'h00a7, 16'h007d, 16'h0050, 16'h0043,
      16'h0039, 16'h0032, 16'h0028, 16'h0021, 16'h001d, 16'h0019, 16'h0032, 16'h0016};
   // typical range, +/- gauss, indexed by coarse code
   localparam logic [11:0] SOCF_RANGE_TAB [16] = '{
      12'h1f4, 12'h096, 12'h0c8, 12'h0fa, 12'h12c, 12'h190, 12'h271, 12'h2ee,
      12'h36b, 12'h3e8, 12'h4e2, 12'h5dc, 12'h6d6, 12'h7d0, 12'h064, 12'h8ca};
endpackage

// *** socf_bank.sv ***
/*
 sensor output configuration bank: apb-programmed fields that steer the
 signal path and output encoder, plus the derived static controls.
 assumes a single 200 mhz clock, synchronous apb master, and a factory
 quiescent default supplied as a static input.
*/
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
module socf_bank
   import socf_pkg::*;
(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   input wire logic signed [11:0] factory_quiescent_default_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic output_protocol_select_out,
   output logic overvoltage_threshold_select_out,
   output logic signed [11:0] quiescent_offset_out,
   output logic [3:0] coarse_gain_range_select_out,
   output logic [15:0] coarse_gain_out,
   output logic [11:0] field_range_out,
   output logic [27:0] total_gain_out,
   output logic [1:0] nibble_format_out,
   output logic nibble_format_valid_out
);
   logic [3:0] gain_q, gain_d;
   logic proto_q, proto_d;
   logic ovt_q, ovt_d;
   logic [11:0] trim_q, trim_d;
   logic trim_set_q, trim_set_d;
   logic [11:0] scrs_q, scrs_d;
   logic [23:0] scrl_q, scrl_d;
   logic [11:0] mult_q, mult_d;
   logic [1:0] nib_q, nib_d;
   logic [31:0] rdata_q, rdata_d;
   logic rdy_q, rdy_d;
   logic err_q, err_d;
   logic proto_o_q, ovt_o_q, nibv_o_q;
   logic [11:0] qoff_o_q, range_o_q;
   logic [3:0] gain_o_q;
   logic [15:0] cg_o_q;
   logic [27:0] tg_o_q;
   logic [1:0] nib_o_q;
   logic setup, hit, commit;
   logic [9:0] addr;
   logic [15:0] coarse_gain_out_src;

   // merge write data under byte strobes
   function automatic logic [31:0] socf_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (st[i])
         begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   assign addr = paddr_in[9:0];
   // reads latch at the setup edge; pready follows in the access cycle
   assign setup = psel_in && !penable_in;
   // writes land only at the access edge where pready is seen high
   assign commit = psel_in && penable_in && rdy_q && pwrite_in && hit;
   assign hit = (paddr_in[31:10] == 22'h0) &&
      (addr == SOCF_ADDR_GAIN || addr == SOCF_ADDR_MODE || addr == SOCF_ADDR_TRIM ||
       addr == SOCF_ADDR_SCRL || addr == SOCF_ADDR_MULT || addr == SOCF_ADDR_SENT ||
       addr == SOCF_ADDR_STAT);

   always_comb
   begin
      logic [31:0] m;
      m = 32'h0;
      gain_d = gain_q;
      proto_d = proto_q;
      ovt_d = ovt_q;
      trim_d = trim_q;
      trim_set_d = trim_set_q;
      scrs_d = scrs_q;
      scrl_d = scrl_q;
      mult_d = mult_q;
      nib_d = nib_q;
      rdata_d = rdata_q;
      rdy_d = setup;
      err_d = setup && !hit;
      if (commit)
      begin
         unique case (addr)
            SOCF_ADDR_GAIN:
            begin
               m = socf_merge({26'h0, gain_q, 2'b00}, pwdata_in, pstrb_in);
               gain_d = m[SOCF_GAIN_LSB +: 4];
            end
            SOCF_ADDR_MODE:
            begin
               m = socf_merge({21'h0, ovt_q, 6'h0, proto_q, 3'h0}, pwdata_in, pstrb_in);
               proto_d = m[SOCF_PROTO_BIT];
               ovt_d = m[SOCF_OVT_BIT];
            end
            SOCF_ADDR_TRIM:
            begin
               m = socf_merge({8'h0, scrs_q, trim_q}, pwdata_in, pstrb_in);
               trim_d = m[11:0];
               scrs_d = m[SOCF_SCRS_LSB +: 12];
               if (pstrb_in[1:0] != 2'b00)
               begin
                  trim_set_d = 1'b1;
               end
            end
            SOCF_ADDR_SCRL:
            begin
               m = socf_merge({8'h0, scrl_q}, pwdata_in, pstrb_in);
               scrl_d = m[23:0];
            end
            SOCF_ADDR_MULT:
            begin
               m = socf_merge({20'h0, mult_q}, pwdata_in, pstrb_in);
               mult_d = m[11:0];
            end
            SOCF_ADDR_SENT:
            begin
               m = socf_merge({27'h0, nib_q, 3'h0}, pwdata_in, pstrb_in);
               nib_d = m[SOCF_NIB_LSB +: 2];
            end
            default:
            begin
               m = 32'h0;
            end
         endcase
      end
      if (setup)
      begin
         rdata_d = 32'h0;
         if (!pwrite_in)
         begin
            unique case (addr)
               SOCF_ADDR_GAIN: rdata_d = {26'h0, gain_q, 2'b00};
               SOCF_ADDR_MODE: rdata_d = {21'h0, ovt_q, 6'h0, proto_q, 3'h0};
               SOCF_ADDR_TRIM: rdata_d = {8'h0, scrs_q, trim_q};
               SOCF_ADDR_SCRL: rdata_d = {8'h0, scrl_q};
               SOCF_ADDR_MULT: rdata_d = {20'h0, mult_q};
               SOCF_ADDR_SENT: rdata_d = {27'h0, nib_q, 3'h0};
               // status: whether the trim has been programmed
               SOCF_ADDR_STAT: rdata_d = {31'h0, trim_set_q};
               default: rdata_d = 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         gain_q <= SOCF_GAIN_RST;
         proto_q <= SOCF_PROTO_SENT;
         ovt_q <= 1'b0;
         trim_q <= 12'h0;
         trim_set_q <= 1'b0;
         scrs_q <= 12'h0;
         scrl_q <= 24'h0;
         mult_q <= SOCF_MULT_RST;
         nib_q <= SOCF_NIB_RST;
         rdata_q <= 32'h0;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
      end
      else
      begin
         gain_q <= gain_d;
         proto_q <= proto_d;
         ovt_q <= ovt_d;
         trim_q <= trim_d;
         trim_set_q <= trim_set_d;
         scrs_q <= scrs_d;
         scrl_q <= scrl_d;
         mult_q <= mult_d;
         nib_q <= nib_d;
         rdata_q <= rdata_d;
         rdy_q <= rdy_d;
         err_q <= err_d;
      end
   end

   // derived controls; scratch fields deliberately feed none of them
   logic proto_o_d, ovt_o_d, nibv_o_d;
   logic [11:0] qoff_o_d, range_o_d;
   logic [15:0] cg_o_d;
   logic [27:0] tg_o_d;

   always_comb
   begin
      proto_o_d = proto_q;
      ovt_o_d = ovt_q;
      qoff_o_d = trim_set_q ? trim_q : factory_quiescent_default_in;
      cg_o_d = SOCF_GAIN_TAB[gain_q];
      range_o_d = SOCF_RANGE_TAB[gain_q];
      // multiplier 0x800 is unity, so product carries 11 fraction bits
      tg_o_d = 28'(SOCF_GAIN_TAB[gain_q] * mult_q);
      nibv_o_d = (proto_q == SOCF_PROTO_SENT);
   end

   // outputs follow fields one cycle late; the quiescent output also follows the factory default input while trim is unprogrammed
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         proto_o_q <= SOCF_PROTO_SENT;
         ovt_o_q <= 1'b0;
         qoff_o_q <= 12'h0;
         gain_o_q <= SOCF_GAIN_RST;
         cg_o_q <= 16'h0;
         range_o_q <= 12'h0;
         tg_o_q <= 28'h0;
         nib_o_q <= SOCF_NIB_RST;
         nibv_o_q <= 1'b0;
      end
      else
      begin
         proto_o_q <= proto_o_d;
         ovt_o_q <= ovt_o_d;
         qoff_o_q <= qoff_o_d;
         gain_o_q <= gain_q;
         cg_o_q <= cg_o_d;
         range_o_q <= range_o_d;
         tg_o_q <= tg_o_d;
         nib_o_q <= nib_q;
         nibv_o_q <= nibv_o_d;
      end
   end

   assign prdata_out = rdata_q;
   assign pready_out = rdy_q;
   assign pslverr_out = err_q;
   assign output_protocol_select_out = proto_o_q;
   assign overvoltage_threshold_select_out = ovt_o_q;
   assign quiescent_offset_out = qoff_o_q;
   assign coarse_gain_range_select_out = gain_o_q;
   assign coarse_gain_out = cg_o_q;
   assign field_range_out = range_o_q;
   assign total_gain_out = tg_o_q;
   assign nibble_format_out = nib_o_q;
   assign nibble_format_valid_out = nibv_o_q;

   // sampled reset: the edge that releases reset must not start an attempt
   AST_PROTO: assert property (@(posedge clk_in) disable iff ($sampled(srst_in))
      1 |=> output_protocol_select_out == $past(proto_q))
      else $error("protocol output does not follow field");
   AST_TRIM: assert property (@(posedge clk_in) disable iff ($sampled(srst_in))
      trim_set_q |=> quiescent_offset_out == $past(trim_q))
      else $error("programmed trim not applied");
   AST_FACT: assert property (@(posedge clk_in) disable iff ($sampled(srst_in))
      !trim_set_q |=> quiescent_offset_out == $past(factory_quiescent_default_in))
      else $error("factory default not applied");
   AST_SCRL: assert property (@(posedge clk_in) disable iff ($sampled(srst_in))
      !(psel_in && pwrite_in && paddr_in[9:0] == SOCF_ADDR_SCRL) |=> $stable(scrl_q))
      else $error("long scratch changed without write");
   AST_SCRS: assert property (@(posedge clk_in) disable iff ($sampled(srst_in))
      !(commit && addr == SOCF_ADDR_TRIM) |=> $stable(scrs_q))
      else $error("short scratch changed without write");
   AST_SCRX: assert property (@(posedge clk_in) disable iff ($sampled(srst_in))
      $changed(scrs_q) && $stable(trim_q) && $stable(trim_set_q) |=> $stable(quiescent_offset_out))
      else $error("scratch write disturbed offset");
   AST_RANGE: assert property (@(posedge clk_in) disable iff ($sampled(srst_in))
      gain_q == 4'h3 |=> field_range_out == 12'h0fa && coarse_gain_out == 16'h00c8)
      else $error("code 3 range wrong");
   AST_DEFG: assert property (@(posedge clk_in) disable iff ($sampled(srst_in))
      gain_q == 4'h0 |=> coarse_gain_out == 16'h0064)
      else $error("default gain wrong");
   AST_HOLD: assert property (@(posedge clk_in) disable iff ($sampled(srst_in))
      !(commit && addr == SOCF_ADDR_GAIN) |=> $stable(gain_q))
      else $error("coarse code changed without write");
   AST_MULT: assert property (@(posedge clk_in) disable iff ($sampled(srst_in))
      1 |=> total_gain_out == 28'($past(coarse_gain_out_src) * $past(mult_q)))
      else $error("total gain not product");
   AST_NIB: assert property (@(posedge clk_in) disable iff ($sampled(srst_in))
      proto_q |=> !nibble_format_valid_out)
      else $error("nibble format valid in pwm");
   AST_OVT: assert property (@(posedge clk_in) disable iff ($sampled(srst_in))
      !(commit && addr == SOCF_ADDR_MODE) ##1 1 |=>
      $stable(overvoltage_threshold_select_out))
      else $error("threshold select changed without write");
   assign coarse_gain_out_src = SOCF_GAIN_TAB[gain_q];
endmodule

// *** tb_sensor_output_config_fields.sv ***
/*
 self-checking bench for socf_bank: apb register access, field outputs.
 assumes one 200 mhz clock and the one-cycle apb answer of the slave.
*/
`timescale 1ns/100ps
module tb_sensor_output_config_fields;
   import socf_pkg::*;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [31:0] paddr_in = 32'h0;
   logic [31:0] pwdata_in = 32'h0;
   logic [3:0] pstrb_in = 4'h0;
   logic signed [11:0] factory_quiescent_default_in = 12'h123;
   logic [31:0] prdata_out;
   logic pready_out, pslverr_out, output_protocol_select_out;
   logic overvoltage_threshold_select_out, nibble_format_valid_out;
   logic signed [11:0] quiescent_offset_out;
   logic [3:0] coarse_gain_range_select_out;
   logic [15:0] coarse_gain_out;
   logic [11:0] field_range_out;
   logic [27:0] total_gain_out;
   logic [1:0] nibble_format_out;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic se;
   localparam logic [31:0] RA [5] = '{SOCF_ADDR_GAIN, SOCF_ADDR_MODE, SOCF_ADDR_MULT,
      SOCF_ADDR_SENT, SOCF_ADDR_STAT};
   localparam logic [31:0] RE [5] = '{32'h0, 32'h0, 32'h800, 32'h0, 32'h0};
   localparam logic [31:0] TA [6] = '{SOCF_ADDR_GAIN, SOCF_ADDR_MODE, SOCF_ADDR_TRIM,
      SOCF_ADDR_SCRL, SOCF_ADDR_MULT, SOCF_ADDR_SENT};
   localparam logic [31:0] TR [6] = '{32'h3c, 32'h408, 32'hffffff, 32'hffffff, 32'hfff, 32'h18};

   socf_bank DUT (.clk_in(clk_in), .srst_in(srst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
      .factory_quiescent_default_in(factory_quiescent_default_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .output_protocol_select_out(output_protocol_select_out),
      .overvoltage_threshold_select_out(overvoltage_threshold_select_out),
      .quiescent_offset_out(quiescent_offset_out),
      .coarse_gain_range_select_out(coarse_gain_range_select_out),
      .coarse_gain_out(coarse_gain_out), .field_range_out(field_range_out),
      .total_gain_out(total_gain_out), .nibble_format_out(nibble_format_out),
      .nibble_format_valid_out(nibble_format_valid_out));

   initial
   begin
      forever #2.5 clk_in = ~clk_in;
   end

   task finish_test();
      if (err_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // whole run is well under a thousand cycles
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles > 3000)
      begin
         err_count++;
         finish_test();
      end
   end

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask

   // request stays on the bus after the answer so a setup may follow at once
   task apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      pstrb_in <= s;
      @(posedge clk_in);
      penable_in <= 1'b1;
      @(posedge clk_in);
      // only the cycle ceiling ends a wait that never sees pready
      while (pready_out !== 1'b1)
      begin
         @(posedge clk_in);
      end
      rd = prdata_out;
      se = pslverr_out;
   endtask

   task settle();
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask

   task outs(input logic [31:0] p, o, q, c, g, r, t, v);
      chk("protocol", p, {31'h0, output_protocol_select_out});
      chk("ovt", o, {31'h0, overvoltage_threshold_select_out});
      chk("quiescent", q, {20'h0, quiescent_offset_out});
      chk("code", c, {28'h0, coarse_gain_range_select_out});
      chk("gain", g, {16'h0, coarse_gain_out});
      chk("range", r, {20'h0, field_range_out});
      chk("total", t, {4'h0, total_gain_out});
      chk("valid", v, {31'h0, nibble_format_valid_out});
   endtask

   initial
   begin
      repeat (16) @(posedge clk_in);
      srst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      outs(0, 0, 32'h123, 0, 32'h64, 32'h1f4, 32'h64 * 32'h800, 1);
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, RA[i], 32'h0, 4'h0);
         chk("reset read", RE[i], rd);
         chk("reset err", 32'h0, {31'h0, se});
      end
      // byte lane 2 only: trim stays unprogrammed
      apb(1'b1, SOCF_ADDR_TRIM, 32'h00ab0000, 4'b0100);
      settle();
      chk("quiescent", 32'h123, {20'h0, quiescent_offset_out});
      chk("ready idle", 32'h0, {31'h0, pready_out});
      apb(1'b1, SOCF_ADDR_TRIM, 32'h00000fae, 4'b0011);
      apb(1'b0, SOCF_ADDR_STAT, 32'h0, 4'h0);
      chk("programmed", 32'h1, rd & 32'h1);
      settle();
      chk("quiescent", 32'hfae, {20'h0, quiescent_offset_out});
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b1, TA[i], 32'hffffffff, 4'hf);
         apb(1'b0, TA[i], 32'h0, 4'h0);
         chk("readback", TR[i], rd);
      end
      settle();
      outs(1, 1, 32'hfff, 32'hf, 32'h16, 32'h8ca, 32'h16 * 32'hfff, 0);
      chk("nibble", 32'h3, {30'h0, nibble_format_out});
      apb(1'b1, SOCF_ADDR_GAIN, 32'h0000000c, 4'hf);
      apb(1'b1, SOCF_ADDR_MULT, 32'h00000800, 4'hf);
      apb(1'b1, SOCF_ADDR_MODE, 32'h0, 4'hf);
      settle();
      outs(0, 0, 32'hfff, 3, 32'hc8, 32'hfa, 32'hc8 * 32'h800, 1);
      apb(1'b1, SOCF_ADDR_SCRL, 32'h00a5a5a5, 4'hf);
      apb(1'b1, SOCF_ADDR_TRIM, 32'h005a0000, 4'b0100);
      apb(1'b0, SOCF_ADDR_SCRL, 32'h0, 4'h0);
      chk("scratch long", 32'h00a5a5a5, rd);
      apb(1'b0, SOCF_ADDR_TRIM, 32'h0, 4'h0);
      chk("scratch short", 32'h005aff, rd >> 8);
      settle();
      outs(0, 0, 32'hfff, 3, 32'hc8, 32'hfa, 32'hc8 * 32'h800, 1);
      apb(1'b0, 32'h40, 32'h0, 4'h0);
      chk("unmapped data", 32'h0, rd);
      chk("unmapped err", 32'h1, {31'h0, se});
      apb(1'b1, 32'h40, 32'hffffffff, 4'hf);
      chk("unmapped err", 32'h1, {31'h0, se});
      settle();
      srst_in <= 1'b1;
      @(posedge clk_in);
      srst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      outs(0, 0, 32'h123, 0, 32'h64, 32'h1f4, 32'h64 * 32'h800, 1);
      finish_test();
   end
endmodule
